// >>> hw/touch_key_pkg.sv
// Shared constants and types of the touch key output interface
package touch_key_pkg;
  // Clock and time base
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  // Times in milliseconds and the derived cycle counts
  localparam int unsigned AR_SHORT_MS = 5000;
  localparam int unsigned AR_MID_MS = 20000;
  localparam int unsigned AR_LONG_MS = 40000;
  localparam int unsigned HOLD_MS = 440;
  localparam int unsigned IDLE_MS = 2000;
  localparam int unsigned SCAN_SLOW_MS = 250;
  localparam int unsigned SCAN_MID_MS = 150;
  localparam int unsigned SCAN_FAST_MS = 40;
  localparam int unsigned AR_SHORT_CYC = AR_SHORT_MS * CYC_PER_MS;
  localparam int unsigned AR_MID_CYC = AR_MID_MS * CYC_PER_MS;
  localparam int unsigned AR_LONG_CYC = AR_LONG_MS * CYC_PER_MS;
  localparam int unsigned HOLD_CYC = HOLD_MS * CYC_PER_MS;
  localparam int unsigned IDLE_CYC = IDLE_MS * CYC_PER_MS;
  localparam int unsigned SCAN_SLOW_CYC = SCAN_SLOW_MS * CYC_PER_MS;
  localparam int unsigned SCAN_MID_CYC = SCAN_MID_MS * CYC_PER_MS;
  localparam int unsigned SCAN_FAST_CYC = SCAN_FAST_MS * CYC_PER_MS;
  // Geometry
  localparam int unsigned NUM_KEYS = 16;
  localparam int unsigned NUM_LINES = 4;
  // Strap codes delivered by the measurement front end
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_R1K5 = 2'h1;
  localparam logic [1:0] STRAP_R5K = 2'h2;
  localparam logic [1:0] STRAP_HIGH = 2'h3;
  // Threshold codes for the sensing front end
  localparam logic [1:0] THR_LOW = 2'h0;
  localparam logic [1:0] THR_MED = 2'h1;
  localparam logic [1:0] THR_HIGH = 2'h2;
  // Register byte offsets
  localparam logic [4:0] REG_KEYS = 5'h00;
  localparam logic [4:0] REG_IRQ_STAT = 5'h04;
  localparam logic [4:0] REG_IRQ_MASK = 5'h08;
  localparam logic [4:0] REG_CONFIG = 5'h0C;
  localparam logic [4:0] REG_KEY_EN = 5'h10;
  // Interrupt status bit positions
  localparam int unsigned IRQ_PRESS_BIT = 0;
  localparam int unsigned IRQ_RELEASE_BIT = 1;
  localparam int unsigned IRQ_STUCK_BIT = 2;
  localparam int unsigned IRQ_BITS = 3;
  // Config register field positions
  localparam int unsigned CFG_AR_LSB = 0;
  localparam int unsigned CFG_SEL_LSB = 2;
  localparam int unsigned CFG_RATE_LSB = 4;
  localparam int unsigned CFG_SENS_LSB = 6;
  localparam int unsigned CFG_MTS_BIT = 8;
  // Reset values
  localparam logic [15:0] KEY_EN_RST = 16'hFFFF;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  // Output interface selection
  typedef enum logic [1:0] {MODE_TRUTH, MODE_ENC, MODE_SCAN} out_mode_type;
endpackage

// >>> hw/key_timer.sv
// Per-key hold-after-release and stuck-key auto-reset timer
`timescale 1ns/1ps
`default_nettype none
module key_timer
  import touch_key_pkg::*;
#(
  parameter int unsigned HOLD = HOLD_CYC
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic touch_i,
  input wire logic ar_en_i,
  input wire logic [31:0] ar_limit_i,
  output logic active_o,
  output logic stuck_o
);
  logic [31:0] touch_cnt_r;
  logic [31:0] hold_cnt_r;
  logic stuck_r;
  logic active_r;
  logic stuck_p_r;
  wire ar_hit = ar_en_i && (touch_cnt_r == ar_limit_i - 32'h0000_0001);

  // Stuck keys stay dark until released, so no hold follows them
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      touch_cnt_r <= 32'h0000_0000;
      hold_cnt_r <= 32'h0000_0000;
      stuck_r <= 1'b0;
      active_r <= 1'b0;
      stuck_p_r <= 1'b0;
    end else begin
      stuck_p_r <= 1'b0;
      if (!touch_i) begin
        stuck_r <= 1'b0;
        touch_cnt_r <= 32'h0000_0000;
        if (active_r && hold_cnt_r == HOLD - 1) begin
          active_r <= 1'b0;
          hold_cnt_r <= 32'h0000_0000;
        end else if (active_r) begin
          hold_cnt_r <= hold_cnt_r + 32'h0000_0001;
        end
      end else if (!stuck_r) begin
        hold_cnt_r <= 32'h0000_0000;
        if (ar_hit) begin
          stuck_r <= 1'b1;
          active_r <= 1'b0;
          stuck_p_r <= 1'b1;
        end else begin
          touch_cnt_r <= touch_cnt_r + 32'h0000_0001;
          active_r <= 1'b1;
        end
      end
    end
  end

  assign active_o = active_r;
  assign stuck_o = stuck_p_r;

  chk_hold_release: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (!touch_i && active_r && hold_cnt_r != HOLD - 1) |=> active_r)
    else $error("key dropped before hold time ended");
  chk_auto_reset: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (touch_i && ar_hit && !stuck_r) |=> (!active_r && stuck_o))
    else $error("stuck key not cleared at timeout");
endmodule
`default_nettype wire

// >>> hw/idle_scan.sv
// Idle detection and periodic wake-up for low power scanning
`timescale 1ns/1ps
`default_nettype none
module idle_scan
  import touch_key_pkg::*;
#(
  parameter int unsigned IDLE = IDLE_CYC,
  parameter int unsigned SLOW = SCAN_SLOW_CYC,
  parameter int unsigned MID = SCAN_MID_CYC,
  parameter int unsigned FAST = SCAN_FAST_CYC
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic any_active_i,
  input wire logic [1:0] rate_i,
  output logic sleep_o,
  output logic scan_en_o
);
  logic [31:0] idle_cnt_r;
  logic [31:0] ivl_cnt_r;
  logic sleep_r;
  logic scan_en_r;
  logic [31:0] ivl;

  // Interval picked from the latched scan rate strap
  always_comb begin
    unique case (rate_i)
      STRAP_GND: ivl = SLOW;
      STRAP_R1K5: ivl = MID;
      default: ivl = FAST;
    endcase
  end
  wire continuous = (rate_i == STRAP_HIGH);
  wire wake = sleep_r && (ivl_cnt_r == ivl - 32'h0000_0001);

  // Continuous rate never sleeps; any activity wakes fully
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idle_cnt_r <= 32'h0000_0000;
      ivl_cnt_r <= 32'h0000_0000;
      sleep_r <= 1'b0;
      scan_en_r <= 1'b1;
    end else begin
      if (any_active_i || continuous) begin
        idle_cnt_r <= 32'h0000_0000;
        sleep_r <= 1'b0;
      end else if (!sleep_r && idle_cnt_r == IDLE - 1) begin
        sleep_r <= 1'b1;
        ivl_cnt_r <= 32'h0000_0000;
      end else if (!sleep_r) begin
        idle_cnt_r <= idle_cnt_r + 32'h0000_0001;
      end else begin
        ivl_cnt_r <= wake ? 32'h0000_0000 : ivl_cnt_r + 32'h0000_0001;
      end
      scan_en_r <= !sleep_r || wake;
    end
  end

  assign sleep_o = sleep_r;
  assign scan_en_o = scan_en_r;

  chk_wake_active: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    any_active_i |=> !sleep_o ##1 scan_en_o)
    else $error("asleep while a key is active");
endmodule
`default_nettype wire

// >>> hw/touch_key_top.sv
// Touch key output interface: straps, key timing, host pins, registers
//
// Overview of operation
// - Sixteen inputs; a grounded sense input is disabled and never reported.
// - Multi-touch enabled when its select input is low, disabled when high.
// - Without multi-touch, the first touched key stays reported until released.
// - Scan mode samples four host scan lines and drives four read lines.
// - Scan lines used depend on valid key count: 4, 3, 2 or 1.
// - Truth mode drives all eight pins: four rows, four columns, unique code.
// - Truth and encoded modes report one key; both exclude multi-touch.
// - Encoded mode outputs key n as n-1; no key gives low interrupt.
// - Interrupt high while any key active, until all are released.
// - Auto reset, scan rate and output select straps read once at reset.
// - Touched key drops after 5, 20 or 40 s, or never.
// - Released key stays reported for 440 ms.
// - One interface active: ground truth, 1.5K encoded, high scan.
// - After two idle seconds, sleep and wake periodically or scan continuously.
// - Threshold from sensitivity strap: low, medium or high.
`timescale 1ns/1ps
`default_nettype none
module touch_key_top
  import touch_key_pkg::*;
#(
  parameter int unsigned AR_SHORT = AR_SHORT_CYC,
  parameter int unsigned AR_MID = AR_MID_CYC,
  parameter int unsigned AR_LONG = AR_LONG_CYC,
  parameter int unsigned HOLD = HOLD_CYC,
  parameter int unsigned IDLE = IDLE_CYC,
  parameter int unsigned SCAN_SLOW = SCAN_SLOW_CYC,
  parameter int unsigned SCAN_MID = SCAN_MID_CYC,
  parameter int unsigned SCAN_FAST = SCAN_FAST_CYC
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [15:0] touch_input_n_i,
  input wire logic [15:0] touch_gnd_i,
  input wire logic multi_touch_select_i,
  input wire logic [1:0] auto_reset_strap_i,
  input wire logic [1:0] out_select_strap_i,
  input wire logic [1:0] scan_rate_strap_i,
  input wire logic [1:0] sensitivity_strap_i,
  input wire logic [3:0] col_pin_i,
  output logic [3:0] col_pin_o,
  output logic [3:0] col_pin_oe_o,
  output logic [3:0] row_pin_o,
  output logic key_int_o,
  output logic [1:0] threshold_o,
  output logic sleep_o,
  output logic scan_en_o,
  input wire logic [4:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  output logic irq_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  // Lowest active index; used for the first-key pick
  function automatic logic [3:0] lowest_index(input logic [15:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = NUM_KEYS - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // Number of valid keys
  function automatic logic [4:0] popcount(input logic [15:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < NUM_KEYS; i++) begin
      n = n + {4'h0, v[i]};
    end
    return n;
  endfunction

  // Strap code to interface choice
  function automatic out_mode_type sel_mode(input logic [1:0] code);
    out_mode_type m;
    m = MODE_SCAN;
    if (code == STRAP_GND) begin
      m = MODE_TRUTH;
    end else if (code == STRAP_R1K5) begin
      m = MODE_ENC;
    end
    return m;
  endfunction

  // Strap capture, once after reset release
  logic strap_done_r;
  logic [1:0] ar_code_r;
  logic [1:0] sel_code_r;
  logic [1:0] rate_code_r;
  logic [1:0] sens_code_r;
  logic [1:0] threshold_r;
  // Taken one edge after release; straps are never sampled under reset
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strap_done_r <= 1'b0;
      ar_code_r <= STRAP_HIGH;
      sel_code_r <= STRAP_HIGH;
      rate_code_r <= STRAP_HIGH;
      sens_code_r <= STRAP_HIGH;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      ar_code_r <= auto_reset_strap_i;
      sel_code_r <= out_select_strap_i;
      rate_code_r <= scan_rate_strap_i;
      sens_code_r <= sensitivity_strap_i;
    end
  end

  // Threshold for the front end; 5K code is not defined, taken as high
  wire [1:0] thr_nxt = (sens_code_r == STRAP_GND) ? THR_LOW :
    (sens_code_r == STRAP_R1K5) ? THR_MED : THR_HIGH;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      threshold_r <= THR_HIGH;
    end else begin
      threshold_r <= thr_nxt;
    end
  end

  out_mode_type mode;
  assign mode = sel_mode(sel_code_r);
  wire mts_en = !multi_touch_select_i;
  wire single = !mts_en || (mode != MODE_SCAN);

  // Auto-reset limit from the latched strap
  wire ar_en = (ar_code_r != STRAP_HIGH);
  wire [31:0] ar_limit = (ar_code_r == STRAP_GND) ? AR_SHORT :
    (ar_code_r == STRAP_R1K5) ? AR_MID : AR_LONG;

  // Key enables: grounded inputs and software-disabled keys drop out
  logic [15:0] key_en_r;
  wire [15:0] disabled = touch_gnd_i | ~key_en_r;
  wire [15:0] touch_ok = touch_input_n_i & ~disabled;
  wire [15:0] key_act;
  wire [15:0] stuck_p;

  genvar g;
  generate
    for (g = 0; g < NUM_KEYS; g++) begin : g_key
      key_timer #(
        .HOLD(HOLD)
      ) u_timer (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .touch_i(touch_ok[g]),
        .ar_en_i(ar_en),
        .ar_limit_i(ar_limit),
        .active_o(key_act[g]),
        .stuck_o(stuck_p[g])
      );
    end
  endgenerate

  // First-key latch for single-key reporting
  logic [3:0] first_idx_r;
  logic first_valid_r;
  // A later press never displaces a key still held or in its hold time
  wire first_keep = first_valid_r && key_act[first_idx_r];
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      first_idx_r <= 4'h0;
      first_valid_r <= 1'b0;
    end else if (!first_keep) begin
      first_idx_r <= lowest_index(key_act);
      first_valid_r <= |key_act;
    end
  end

  wire [15:0] first_vec = first_valid_r ? (16'h0001 << first_idx_r) : 16'h0000;
  // Masked at the report too: a key disabled during its hold time leaves rep_vec at once; truth and encoded pins keep it until the hold ends
  wire [15:0] rep_vec = (single ? first_vec : key_act) & ~disabled;
  wire rep_any = |rep_vec;

  idle_scan #(
    .IDLE(IDLE),
    .SLOW(SCAN_SLOW),
    .MID(SCAN_MID),
    .FAST(SCAN_FAST)
  ) u_idle (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .any_active_i(|key_act),
    .rate_i(rate_code_r),
    .sleep_o(sleep_o),
    .scan_en_o(scan_en_o)
  );

  // Scan lines in use follow the valid key count
  wire [4:0] n_valid = popcount(~disabled);
  wire [3:0] lines_used = (n_valid > 5'd12) ? 4'hF :
    (n_valid > 5'd8) ? 4'h7 : (n_valid > 5'd4) ? 4'h3 : 4'h1;
  // Active-low scan lines; unused ones are masked off by lines_used, whatever the host drives
  wire [3:0] scan_sel = ~col_pin_i & lines_used;
  wire [3:0] read_low;
  generate
    for (g = 0; g < NUM_LINES; g++) begin : g_read
      assign read_low[g] = |(scan_sel & {rep_vec[12 + g], rep_vec[8 + g],
        rep_vec[4 + g], rep_vec[g]});
    end
  endgenerate

  // Truth code: one-hot row index/4 and column index mod 4
  wire [3:0] tt_row = first_valid_r ? (4'h1 << first_idx_r[3:2]) : 4'h0;
  wire [3:0] tt_col = first_valid_r ? (4'h1 << first_idx_r[1:0]) : 4'h0;

  // Pin selection per interface
  logic [3:0] row_nxt;
  logic [3:0] col_nxt;
  logic [3:0] oe_nxt;
  always_comb begin
    unique case (mode)
      MODE_TRUTH: begin
        row_nxt = tt_row;
        col_nxt = tt_col;
        oe_nxt = 4'hF;
      end
      MODE_ENC: begin
        row_nxt = first_valid_r ? first_idx_r : 4'h0;
        col_nxt = 4'h0;
        oe_nxt = 4'h0;
      end
      MODE_SCAN: begin
        row_nxt = ~read_low;
        col_nxt = 4'h0;
        oe_nxt = 4'h0;
      end
    endcase
  end

  // Pins and host interrupt registered so they move together
  logic [3:0] row_r;
  logic [3:0] col_r;
  logic [3:0] oe_r;
  logic key_int_r;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      row_r <= 4'h0;
      col_r <= 4'h0;
      oe_r <= 4'h0;
      key_int_r <= 1'b0;
    end else begin
      row_r <= row_nxt;
      col_r <= col_nxt;
      oe_r <= oe_nxt;
      key_int_r <= rep_any;
    end
  end
  assign row_pin_o = row_r;
  assign col_pin_o = col_r;
  assign col_pin_oe_o = oe_r;
  assign key_int_o = key_int_r;
  assign threshold_o = threshold_r;

  // Avalon slave: one wait state, then the access completes
  logic ack_r;
  logic [31:0] rdata_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic rep_any_q;
  wire req = read_i || write_i;
  wire done = req && ack_r;
  wire wr_done = write_i && ack_r;
  wire rd_stat = read_i && ack_r && (address_i == REG_IRQ_STAT);
  assign waitrequest_o = req && !ack_r;

  wire [31:0] cfg_word = {23'h00_0000, mts_en, sens_code_r, rate_code_r,
    sel_code_r, ar_code_r};
  wire [31:0] rd_mux = (address_i == REG_KEYS) ? {16'h0000, rep_vec} :
    (address_i == REG_IRQ_STAT) ? {29'h0000_0000, irq_stat_r} :
    (address_i == REG_IRQ_MASK) ? {29'h0000_0000, irq_mask_r} :
    (address_i == REG_CONFIG) ? cfg_word :
    (address_i == REG_KEY_EN) ? {16'h0000, key_en_r} : 32'h0000_0000;

  // Events; a set in the clearing cycle survives
  wire [2:0] ev;
  assign ev[IRQ_PRESS_BIT] = rep_any && !rep_any_q;
  assign ev[IRQ_RELEASE_BIT] = !rep_any && rep_any_q;
  assign ev[IRQ_STUCK_BIT] = |stuck_p;
  // Clear only what the read returned; a bit set after the capture edge survives
  wire [2:0] stat_nxt = (rd_stat ? (irq_stat_r & ~rdata_r[2:0]) : irq_stat_r) | ev;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      irq_stat_r <= 3'h0;
      irq_mask_r <= IRQ_MASK_RST;
      key_en_r <= KEY_EN_RST;
      rep_any_q <= 1'b0;
    end else begin
      ack_r <= req && !ack_r;
      rep_any_q <= rep_any;
      irq_stat_r <= stat_nxt;
      if (read_i && !ack_r) begin
        rdata_r <= rd_mux;
      end
      if (wr_done && address_i == REG_IRQ_MASK) begin
        irq_mask_r <= writedata_i[2:0];
      end
      if (wr_done && address_i == REG_KEY_EN) begin
        key_en_r <= writedata_i[15:0];
      end
    end
  end
  assign readdata_o = rdata_r;
  assign irq_o = |(irq_stat_r & irq_mask_r);

  // Checks
  chk_gnd_never_shown: assert property ((rep_vec & touch_gnd_i) == 16'h0000)
    else $error("grounded input reported");
  chk_single_onehot: assert property (single |-> $onehot0(rep_vec))
    else $error("more than one key reported");
  chk_first_key_kept: assert property (first_keep |=>
    first_idx_r == $past(first_idx_r) && first_valid_r)
    else $error("first key replaced while still active");
  chk_int_follows: assert property (rep_any |=> key_int_o)
    else $error("interrupt low while key active");
  chk_int_drops: assert property (!rep_any |=> !key_int_o)
    else $error("interrupt high with no key");
  chk_enc_code: assert property ((mode == MODE_ENC && first_valid_r) |=>
    row_pin_o == $past(first_idx_r))
    else $error("encoded value wrong");
  chk_strap_frozen: assert property (strap_done_r |=>
    $stable(sel_code_r) && $stable(ar_code_r) && $stable(rate_code_r))
    else $error("strap changed after capture");
  chk_truth_drive: assert property (strap_done_r && mode == MODE_TRUTH |=>
    col_pin_oe_o == 4'hF)
    else $error("truth mode not driving columns");
  chk_scan_idle: assert property ((mode == MODE_SCAN && col_pin_i == 4'hF) |=>
    row_pin_o == 4'hF)
    else $error("read line low with no scan line");
endmodule
`default_nettype wire

// >>> verification/keypad_host_model.sv
// Host side model: legacy keypad scanner and interrupt latch
`timescale 1ns/1ps
`default_nettype none
module keypad_host_model (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [2:0] line_sel_i,
  input wire logic [3:0] row_pin_i,
  input wire logic key_int_i,
  output logic [3:0] scan_o,
  output logic [3:0] latched_o
);
  logic int_d_r;
  // One scan line low at a time, unused lines stay high
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scan_o <= 4'hf;
    end else if (line_sel_i < 3'h4) begin
      scan_o <= ~(4'h1 << line_sel_i[1:0]);
    end else begin
      scan_o <= 4'hf;
    end
  end
  // Interrupt rise used as latch strobe for the output lines
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      int_d_r <= 1'b0;
      latched_o <= 4'h0;
    end else begin
      int_d_r <= key_int_i;
      if (key_int_i && !int_d_r) begin
        latched_o <= row_pin_i;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/touch_key_top_tb.sv
// Self-checking bench of the touch key output interface
`timescale 1ns/1ps
`default_nettype none
module touch_key_top_tb;
  import touch_key_pkg::*;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [15:0] touch_i = 16'h0000;
  logic [15:0] gnd_i = 16'h0000;
  logic mts_i = 1'b1;
  logic [1:0] ar_i = 2'h3;
  logic [1:0] sel_i = 2'h3;
  logic [1:0] rate_i = 2'h3;
  logic [1:0] sens_i = 2'h3;
  logic [2:0] line_sel = 3'h4;
  logic [4:0] address_i = 5'h00;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0000_0000;
  logic [31:0] readdata_o;
  logic waitrequest_o;
  logic irq_o;
  logic [3:0] col_o, col_oe, row_o, scan_col, latched, col_wire;
  logic key_int_o, sleep_o, scan_en_o;
  logic [1:0] threshold_o;
  logic [31:0] q;
  int error_cnt = 0;
  int checks = 0;
  // Pin level seen by both sides of the shared column lines
  assign col_wire = (col_oe & col_o) | (~col_oe & scan_col);
  always #25 mclk_i = ~mclk_i;
  touch_key_top #(.AR_SHORT(50), .HOLD(20), .IDLE(40), .SCAN_SLOW(15)) touch_key_top_inst (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .touch_input_n_i(touch_i), .touch_gnd_i(gnd_i),
    .multi_touch_select_i(mts_i), .auto_reset_strap_i(ar_i), .out_select_strap_i(sel_i),
    .scan_rate_strap_i(rate_i), .sensitivity_strap_i(sens_i), .col_pin_i(col_wire),
    .col_pin_o(col_o), .col_pin_oe_o(col_oe), .row_pin_o(row_o), .key_int_o(key_int_o),
    .threshold_o(threshold_o), .sleep_o(sleep_o), .scan_en_o(scan_en_o),
    .address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .irq_o(irq_o));
  keypad_host_model keypad_host_model_inst (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .line_sel_i(line_sel), .row_pin_i(row_o), .key_int_i(key_int_o), .scan_o(scan_col),
    .latched_o(latched));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    if (error_cnt == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // Avalon cycle: hold the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    address_i <= a;
    writedata_i <= d;
    read_i <= !wr;
    write_i <= wr;
    do begin
      @(posedge mclk_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      summarize();
    end
    q = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask
  // New strap set applied across a full reset
  task automatic rst(input logic [1:0] s, input logic [1:0] a, input logic [1:0] r,
                     input logic [1:0] e);
    @(posedge mclk_i);
    nrst_i <= 1'b0;
    touch_i <= 16'h0000;
    gnd_i <= 16'h0000;
    sel_i <= s;
    ar_i <= a;
    rate_i <= r;
    sens_i <= e;
    wt(10);
    nrst_i <= 1'b1;
    wt(3);
  endtask
  // Encoded output, single key, hold, interrupt registers
  task automatic enc_test();
    rst(2'h1, 2'h3, 2'h3, 2'h1);
    chk("thr", threshold_o, 1);
    touch_i[5] <= 1'b1;
    wt(5);
    chk("enc", row_o, 5);
    chk("int", key_int_o, 1);
    chk("latch", latched, 5);
    touch_i[2] <= 1'b1;
    wt(5);
    chk("first", row_o, 5);
    touch_i <= 16'h0000;
    wt(12);
    chk("hold", key_int_o, 1);
    wt(15);
    chk("drop", key_int_o, 0);
    bus(1'b0, REG_IRQ_STAT, 0);
    chk("stat", q, 32'h0000_0003);
    bus(1'b0, REG_IRQ_STAT, 0);
    chk("stat_clr", q, 0);
    bus(1'b1, REG_CONFIG, 32'h0000_0000);
    bus(1'b0, REG_CONFIG, 0);
    chk("cfg", q, 32'h0000_0077);
    bus(1'b0, REG_KEY_EN, 0);
    chk("key_en", q, 32'h0000_ffff);
    bus(1'b0, 5'h14, 0);
    chk("unmapped", q, 0);
    bus(1'b1, REG_IRQ_MASK, 32'h0000_0001);
    touch_i[0] <= 1'b1;
    wt(5);
    chk("irq", irq_o, 1);
    bus(1'b0, REG_KEYS, 0);
    chk("keys", q, 32'h0000_0001);
    bus(1'b0, REG_IRQ_STAT, 0);
    wt(1);
    chk("irq_clr", irq_o, 0);
  endtask
  // Truth table codes, auto reset, grounded input
  task automatic truth_test();
    rst(2'h0, 2'h0, 2'h3, 2'h0);
    sens_i <= 2'h1;
    chk("thr", threshold_o, 0);
    touch_i[6] <= 1'b1;
    wt(5);
    chk("row", row_o, 4'b0010);
    chk("col", col_o, 4'b0100);
    chk("oe", col_oe, 4'hf);
    wt(55);
    chk("stuck", key_int_o, 0);
    touch_i[6] <= 1'b0;
    wt(30);
    gnd_i[6] <= 1'b1;
    touch_i[6] <= 1'b1;
    wt(5);
    chk("gnd", key_int_o, 0);
    chk("thr_keep", threshold_o, 0);
  endtask
  // Key scan with multi-touch, then idle sleep
  task automatic scan_test();
    int n;
    rst(2'h3, 2'h3, 2'h0, 2'h3);
    mts_i <= 1'b0;
    chk("thr", threshold_o, 2);
    chk("oe", col_oe, 4'h0);
    touch_i[1] <= 1'b1;
    touch_i[5] <= 1'b1;
    line_sel <= 3'h0;
    wt(5);
    chk("line0", row_o, 4'b1101);
    line_sel <= 3'h1;
    wt(4);
    chk("line1", row_o, 4'b1101);
    line_sel <= 3'h2;
    wt(4);
    chk("line2", row_o, 4'hf);
    bus(1'b1, REG_KEY_EN, 32'h0000_0F0F);
    touch_i[9] <= 1'b1;
    wt(5);
    chk("lines_used", row_o, 4'hf);
    line_sel <= 3'h4;
    touch_i <= 16'h0000;
    wt(75);
    chk("sleep", sleep_o, 1);
    n = 0;
    repeat (30) begin
      @(posedge mclk_i);
      if (scan_en_o === 1'b1) n++;
    end
    chk("wake", n, 2);
  endtask
  // Watchdog on a hung bus or design
  initial begin
    wt(5000);
    error_cnt++;
    summarize();
  end
  initial begin
    enc_test();
    mts_i <= 1'b1;
    truth_test();
    scan_test();
    summarize();
  end
endmodule
`default_nettype wire
